// ---- rtl/tcc_defines.svh ----
// Register offsets, field positions, reset values and fixed counts for the timer channel block
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH
`define TCC_OFS_CONTROL      16'hE000
`define TCC_OFS_MODE_CFG     16'hE01C
`define TCC_OFS_ENABLE_POL   16'hE020
`define TCC_OFS_COUNTER      16'hE024
`define TCC_OFS_DIVIDER      16'hE028
`define TCC_OFS_CH3_COMPARE  16'hE03C
`define TCC_OFS_CH4_COMPARE  16'hE040
`define TCC_RESET_WORD       32'h00000000
// Mode register: channel 3 field group at bit 0, channel 4 at bit 8
`define TCC_MODE_GROUP_W     8
`define TCC_DIR_POS          0
`define TCC_FAST_POS         2
`define TCC_BUF_POS          3
`define TCC_OMODE_POS        4
`define TCC_CDIV_POS         2
`define TCC_FILT_POS         4
// Enable register: channel n group at 4*(n-1)
`define TCC_EN_BASE          8
`define TCC_EN_GROUP_W       4
`define TCC_EN_POS           0
`define TCC_POL_POS          1
`define TCC_ENPOL_MASK       32'h00003333
// Control register bits
`define TCC_CTL_RUN          0
`define TCC_CTL_DOWN         1
`define TCC_CTL_ONE_PULSE    2
`define TCC_CTL_TRIG_START   3
`define TCC_CTL_TSEL_POS     4
`define TCC_CTL_UPDATE_GEN   8
`define TCC_CTL_MASK         32'h0000003F
`define TCC_DIVIDER_MASK     32'h0000000F
`define TCC_COUNT_MAX        16'hFFFF
`endif

// ---- rtl/tcc_pkg.sv ----
// Types shared by the timer channel block
package tcc_pkg;
  typedef enum logic [2:0] {
    OM_FROZEN     = 3'b000,
    OM_SET_MATCH  = 3'b001,
    OM_CLR_MATCH  = 3'b010,
    OM_TOGGLE     = 3'b011,
    OM_FORCE_LOW  = 3'b100,
    OM_FORCE_HIGH = 3'b101,
    OM_PWM1       = 3'b110,
    OM_PWM2       = 3'b111
  } out_mode_t;
  typedef enum logic [1:0] {
    DIR_OUTPUT    = 2'b00,
    DIR_OWN_PIN   = 2'b01,
    DIR_OTHER_PIN = 2'b10,
    DIR_TRIGGER   = 2'b11
  } direction_t;
endpackage

// ---- rtl/timer_channel_capture_compare_cfg.sv ----
// Capture/compare channels 3 and 4 of a general-purpose timer, with a classic Wishbone slave
// Functional notes
// (R1) Mode 000 ignores compare matches; the reference keeps its level.
// (R2) Mode 001 sets the reference on match, mode 010 clears it on match.
// (R3) Mode 011 toggles on match; 100 forces inactive; 101 forces active.
// (R4) Mode 110: up active while counter below compare; down inactive while above.
// (R5) Mode 111: up inactive while counter below compare; down active while above.
// (R6) PWM level changes only on comparison change or on leaving frozen mode.
// (R7) Buffer disabled: compare writes reach the active register at once.
// (R8) Buffer enabled: writes go to buffer, copied to active at each update.
// (R9) Software uses PWM unbuffered only together with one-pulse mode.
// (R10) Fast enable clear: output follows comparison; trigger-to-output at least 5 cycles.
// (R11) Fast enable set in PWM: trigger edge forces compare level within 3 cycles.
// (R12) Output fields act only for output direction, input fields only for inputs.
// (R13) Input filter passes a new level after N agreeing samples.
// (R14) Filter codes 0000-0111: full, half, quarter rate with listed sample counts.
// (R15) Filter codes 1000-1111: eighth, sixteenth, thirty-second rate with listed counts.
// (R16) Capture divider: every edge, every 2, every 4, or every 6 events.
// (R17) Channel 4 direction: output, input 4, input 3, or internal trigger.
// (R18) Channel 3 direction in bits 1:0: output, input 3, input 4, trigger.
// (R19) Software changes direction only while the channel is disabled.
// (R20) Output polarity 0 active high, 1 active low versus the reference.
// (R21) Input polarity set inverts the input and captures on falling edges.
// (R22) Enable bit gates output or capture; channel 4 enable bit 12, polarity 13.
// (R23) Channel 3 at bits 9/8, channel 2 at 5/4, channel 1 at 1/0.
// (R24) Channel 3 mode fields mirror channel 4 in the low byte.
// (R25) Counter clock divided by two to the 4-bit exponent, loaded at update.
`include "tcc_defines.svh"

module timer_channel_capture_compare_cfg
  import tcc_pkg::*;
(
  input wire logic clk_i,            // Peripheral clock, 25 MHz
  input wire logic rst_i,            // Synchronous reset, active high
  input wire logic cyc_i,            // Wishbone cycle
  input wire logic stb_i,            // Wishbone strobe
  input wire logic we_i,             // Wishbone write enable
  input wire logic [15:0] adr_i,     // Wishbone byte address
  input wire logic [3:0] sel_i,      // Wishbone byte selects
  input wire logic [31:0] dat_i,     // Wishbone write data
  output logic [31:0] dat_o,         // Wishbone read data
  output logic ack_o,                // Wishbone acknowledge
  input wire logic ch3_pin_i,        // Channel 3 pin level
  input wire logic ch4_pin_i,        // Channel 4 pin level
  input wire logic [3:0] trigger_i,  // Internal trigger sources
  output logic ch3_out_o,            // Channel 3 output level
  output logic ch3_oe_o,             // Channel 3 output enable
  output logic ch4_out_o,            // Channel 4 output level
  output logic ch4_oe_o,             // Channel 4 output enable
  output logic ch3_capture_o,        // Channel 3 capture pulse
  output logic ch4_capture_o,        // Channel 4 capture pulse
  output logic update_o              // Update event pulse
);

  // Apply byte selects to a register word
  function automatic logic [31:0] merge_sel(input logic [31:0] old, input logic [31:0] wdat,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = wdat[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Filter code to {rate exponent, sample count}
  function automatic logic [6:0] filter_decode(input logic [3:0] code);
    logic [6:0] res;
    res = 7'h01;
    unique case (code) // [R14] [R15]
      4'h0: res = {3'd0, 4'd1};
      4'h1: res = {3'd0, 4'd2};
      4'h2: res = {3'd0, 4'd4};
      4'h3: res = {3'd0, 4'd8};
      4'h4: res = {3'd1, 4'd6};
      4'h5: res = {3'd1, 4'd8};
      4'h6: res = {3'd2, 4'd6};
      4'h7: res = {3'd2, 4'd8};
      4'h8: res = {3'd3, 4'd6};
      4'h9: res = {3'd3, 4'd8};
      4'hA: res = {3'd4, 4'd5};
      4'hB: res = {3'd4, 4'd6};
      4'hC: res = {3'd4, 4'd8};
      4'hD: res = {3'd5, 4'd5};
      4'hE: res = {3'd5, 4'd6};
      4'hF: res = {3'd5, 4'd8};
    endcase
    return res;
  endfunction

  // Capture divider code to events per capture
  function automatic logic [2:0] cdiv_events(input logic [1:0] code);
    logic [2:0] res;
    res = 3'd1;
    unique case (code) // [R16]
      2'b00: res = 3'd1;
      2'b01: res = 3'd2;
      2'b10: res = 3'd4;
      2'b11: res = 3'd6;
    endcase
    return res;
  endfunction

  logic [31:0] control;
  logic [31:0] mode_cfg;
  logic [31:0] enable_pol;
  logic [31:0] clock_divider;
  logic [15:0] counter;
  logic [3:0] divider_shadow;
  logic [14:0] presc_cnt;
  logic [4:0] sample_div;
  logic [1:0] pin_meta;
  logic [1:0] pin_sync;
  logic [3:0] trg_meta;
  logic [3:0] trg_sync;
  logic trg_prev;
  logic [15:0] cmp_rd [2];
  logic [1:0] cap_pulse;
  logic [1:0] ref_lvl;

  // Bus decode; single-cycle registered answer
  wire access = cyc_i & stb_i & ~ack_o;
  wire wr = access & we_i;
  wire hit_ctl = adr_i == `TCC_OFS_CONTROL;
  wire hit_mode = adr_i == `TCC_OFS_MODE_CFG;
  wire hit_enp = adr_i == `TCC_OFS_ENABLE_POL;
  wire hit_cnt = adr_i == `TCC_OFS_COUNTER;
  wire hit_div = adr_i == `TCC_OFS_DIVIDER;
  wire [1:0] hit_cmp = {adr_i == `TCC_OFS_CH4_COMPARE, adr_i == `TCC_OFS_CH3_COMPARE};
  wire [31:0] wr_ctl = merge_sel(control, dat_i, sel_i);
  wire [31:0] wr_cnt = merge_sel({16'h0000, counter}, dat_i, sel_i);
  wire update_gen = wr & hit_ctl & sel_i[1] & dat_i[`TCC_CTL_UPDATE_GEN];
  wire [31:0] rd_mux = hit_ctl ? control :
                       hit_mode ? mode_cfg :
                       hit_enp ? enable_pol :
                       hit_cnt ? {16'h0000, counter} :
                       hit_div ? clock_divider :
                       hit_cmp[0] ? {16'h0000, cmp_rd[0]} :
                       hit_cmp[1] ? {16'h0000, cmp_rd[1]} : 32'h00000000;

  // Counter engine: prescaled tick, wrap at either end gives an update
  wire down = control[`TCC_CTL_DOWN];
  wire [14:0] presc_limit = 15'((32'h1 << divider_shadow) - 32'h1);
  wire count_tick = control[`TCC_CTL_RUN] & (presc_cnt == presc_limit);
  wire wrap = count_tick & (down ? (counter == 16'h0000) : (counter == `TCC_COUNT_MAX));
  wire update_evt = wrap | update_gen;

  // Selected internal trigger, edge after synchronisation
  wire trg_now = trg_sync[control[`TCC_CTL_TSEL_POS +: 2]];
  wire trg_edge = trg_now & ~trg_prev;

  // Bus slave
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= `TCC_RESET_WORD;
    end else begin
      ack_o <= access;
      dat_o <= access ? rd_mux : `TCC_RESET_WORD;
    end
  end

  // Configuration registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_cfg <= `TCC_RESET_WORD;
      enable_pol <= `TCC_RESET_WORD;
      clock_divider <= `TCC_RESET_WORD;
    end else if (wr) begin
      if (hit_mode) mode_cfg <= merge_sel(mode_cfg, dat_i, sel_i) & 32'h0000FFFF;
      if (hit_enp) enable_pol <= merge_sel(enable_pol, dat_i, sel_i) & `TCC_ENPOL_MASK; // [R22] [R23]
      if (hit_div) clock_divider <= merge_sel(clock_divider, dat_i, sel_i) & `TCC_DIVIDER_MASK;
    end
  end

  // Control: run bit set by trigger start wins over a clearing write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      control <= `TCC_RESET_WORD;
    end else begin
      if (wr & hit_ctl) control <= wr_ctl & `TCC_CTL_MASK;
      if (wrap & control[`TCC_CTL_ONE_PULSE]) control[`TCC_CTL_RUN] <= 1'b0;
      if (trg_edge & control[`TCC_CTL_TRIG_START]) control[`TCC_CTL_RUN] <= 1'b1; // [R10]
    end
  end

  // Counter, prescaler and its shadow exponent
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      counter <= 16'h0000;
      presc_cnt <= 15'h0000;
      divider_shadow <= 4'h0;
    end else begin
      if (update_gen) begin
        counter <= down ? `TCC_COUNT_MAX : 16'h0000;
        presc_cnt <= 15'h0000;
      end else if (wr & hit_cnt) begin
        counter <= wr_cnt[15:0];
      end else if (count_tick) begin
        counter <= down ? counter - 16'h0001 : counter + 16'h0001;
        presc_cnt <= 15'h0000;
      end else if (control[`TCC_CTL_RUN]) begin
        presc_cnt <= presc_cnt + 15'h0001;
      end
      if (update_evt) divider_shadow <= clock_divider[3:0]; // [R25]
    end
  end

  // Two-flop synchronisers for pins and triggers, plus filter sample divider
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta <= 2'b00;
      pin_sync <= 2'b00;
      trg_meta <= 4'h0;
      trg_sync <= 4'h0;
      trg_prev <= 1'b0;
      sample_div <= 5'h00;
      update_o <= 1'b0;
    end else begin
      pin_meta <= {ch4_pin_i, ch3_pin_i};
      pin_sync <= pin_meta;
      trg_meta <= trigger_i;
      trg_sync <= trg_meta;
      trg_prev <= trg_now;
      sample_div <= sample_div + 5'h01;
      update_o <= update_evt;
    end
  end

  // Per channel: index 0 is channel 3, index 1 is channel 4
  for (genvar c = 0; c < 2; c++) begin : g_ch
    localparam int MB = c * `TCC_MODE_GROUP_W;
    localparam int EB = `TCC_EN_BASE + c * `TCC_EN_GROUP_W;
    direction_t dir;
    out_mode_t omode;
    out_mode_t prev_mode;
    logic [15:0] cmp_buf;
    logic [15:0] cmp_act;
    logic [3:0] agree_cnt;
    logic [2:0] ev_cnt;
    logic filt;
    logic filt_prev;
    logic ref_q;
    logic prev_lvl;
    logic cap_q;
    wire en = enable_pol[EB + `TCC_EN_POS];
    wire pol = enable_pol[EB + `TCC_POL_POS];
    wire buf_en = mode_cfg[MB + `TCC_BUF_POS];
    wire fast_en = mode_cfg[MB + `TCC_FAST_POS];
    wire is_out = dir == DIR_OUTPUT; // [R12]
    assign dir = direction_t'(mode_cfg[MB + `TCC_DIR_POS +: 2]); // [R17] [R18] [R24]
    assign omode = out_mode_t'(mode_cfg[MB + `TCC_OMODE_POS +: 3]);

    // Input source by direction; own pin, the other channel's pin, or trigger
    wire src = (dir == DIR_OWN_PIN) ? pin_sync[c] :
               (dir == DIR_OTHER_PIN) ? pin_sync[1-c] : trg_now; // [R17] [R18]
    wire [6:0] fdec = filter_decode(mode_cfg[MB + `TCC_FILT_POS +: 4]);
    wire [4:0] rate_mask = 5'((32'h1 << fdec[6:4]) - 32'h1);
    wire sample_tick = (sample_div & rate_mask) == 5'h00;
    wire [3:0] agree_next = agree_cnt + 4'h1;
    // Edge of the polarity-adjusted filtered input
    wire cap_evt = ~is_out & en & ((filt ^ pol) & ~(filt_prev ^ pol)); // [R21] [R22]
    wire [2:0] ev_next = ev_cnt + 3'd1;
    wire capture = cap_evt & (ev_next == cdiv_events(mode_cfg[MB + `TCC_CDIV_POS +: 2])); // [R16]

    // Comparison results and PWM levels
    wire eq = counter == cmp_act;
    wire lt = counter < cmp_act;
    wire gt = counter > cmp_act;
    wire pwm1 = down ? ~gt : lt; // [R4]
    wire pwm2 = down ? gt : ~lt; // [R5]
    wire is_pwm = (omode == OM_PWM1) | (omode == OM_PWM2);
    wire pwm_lvl = (omode == OM_PWM1) ? pwm1 : pwm2;
    wire cmp_wr = wr & hit_cmp[c];
    wire [31:0] cmp_wdat = merge_sel({16'h0000, cmp_buf}, dat_i, sel_i);

    // Digital filter; only input direction uses it
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        filt <= 1'b0;
        filt_prev <= 1'b0;
        agree_cnt <= 4'h0;
      end else begin
        filt_prev <= filt;
        if (is_out) begin
          agree_cnt <= 4'h0;
        end else if (sample_tick) begin
          if (src == filt) begin
            agree_cnt <= 4'h0;
          end else if (agree_next >= fdec[3:0]) begin
            filt <= src; // [R13]
            agree_cnt <= 4'h0;
          end else begin
            agree_cnt <= agree_next;
          end
        end
      end
    end

    // Capture event counting; disabled channel keeps its count at zero
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        ev_cnt <= 3'd0;
        cap_q <= 1'b0;
      end else begin
        cap_q <= capture;
        if (is_out | ~en) ev_cnt <= 3'd0;
        else if (capture) ev_cnt <= 3'd0;
        else if (cap_evt) ev_cnt <= ev_next;
      end
    end

    // Compare buffer and active register; a capture beats a bus write
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cmp_buf <= 16'h0000;
        cmp_act <= 16'h0000;
      end else if (capture) begin
        cmp_buf <= counter;
        cmp_act <= counter;
      end else begin
        if (cmp_wr) cmp_buf <= cmp_wdat[15:0];
        if (cmp_wr & ~(is_out & buf_en)) cmp_act <= cmp_wdat[15:0]; // [R7]
        else if (update_evt & is_out & buf_en) cmp_act <= cmp_buf; // [R8]
      end
    end

    // Reference generation; unbuffered PWM relies on one-pulse use [R9]
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        ref_q <= 1'b0;
        prev_mode <= OM_FROZEN;
        prev_lvl <= 1'b0;
      end else begin
        prev_mode <= omode;
        prev_lvl <= pwm_lvl;
        if (is_out) begin
          if (fast_en & is_pwm & trg_edge) begin
            ref_q <= omode == OM_PWM2; // [R11]
          end else begin
            unique case (omode)
              OM_FROZEN: ref_q <= ref_q; // [R1]
              OM_SET_MATCH: if (eq) ref_q <= 1'b1; // [R2]
              OM_CLR_MATCH: if (eq) ref_q <= 1'b0; // [R2]
              OM_TOGGLE: if (eq) ref_q <= ~ref_q; // [R3]
              OM_FORCE_LOW: ref_q <= 1'b0; // [R3]
              OM_FORCE_HIGH: ref_q <= 1'b1; // [R3]
              OM_PWM1, OM_PWM2: if (prev_mode == OM_FROZEN || pwm_lvl != prev_lvl) ref_q <= pwm_lvl; // [R6]
            endcase
          end
        end
      end
    end

    assign cmp_rd[c] = cmp_buf;
    assign cap_pulse[c] = cap_q;
    assign ref_lvl[c] = ref_q;
  end

  // Pin drive: polarity on the reference, enable gates drive
  wire [1:0] out_on = {g_ch[1].is_out & g_ch[1].en, g_ch[0].is_out & g_ch[0].en}; // [R22]
  wire [1:0] out_pol = {g_ch[1].pol, g_ch[0].pol};
  wire [1:0] out_lvl = out_on & (ref_lvl ^ out_pol); // [R20]

  // Registered pin outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ch3_out_o <= 1'b0;
      ch4_out_o <= 1'b0;
      ch3_oe_o <= 1'b0;
      ch4_oe_o <= 1'b0;
    end else begin
      ch3_out_o <= out_lvl[0];
      ch4_out_o <= out_lvl[1];
      ch3_oe_o <= out_on[0];
      ch4_oe_o <= out_on[1];
    end
  end

  assign ch3_capture_o = cap_pulse[0];
  assign ch4_capture_o = cap_pulse[1];

endmodule

// ---- sim/tb_timer_channel_capture_compare_cfg.sv ----
// Self-checking bench for the timer channel block
module tb_timer_channel_capture_compare_cfg;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [15:0] adr_i = 16'h0000;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 32'h00000000;
  logic [31:0] dat_o, rd;
  logic ack_o, ch3_out_o, ch3_oe_o, ch4_out_o, ch4_oe_o, ch3_capture_o, ch4_capture_o, update_o, ch3_pin, ch4_pin;
  logic [3:0] trigger;
  logic [2:0] ext = 3'h0;
  // Rows: mode byte, control byte, counter, expected level
  logic [31:0] tbl [12] = '{32'h50004001, 32'h00004001, 32'h20004000, 32'h00004000, 32'h68001001, 32'h68004000,
    32'h68024001, 32'h68028000, 32'h78028001, 32'h78024000, 32'h78004001, 32'h78001000};
  int fail_count = 0;
  int checks = 0;
  int caps = 0;
  int ups = 0;
  int mark;
  int i;
  timer_channel_capture_compare_cfg DUT (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .ch3_pin_i(ch3_pin), .ch4_pin_i(ch4_pin), .trigger_i(trigger), .ch3_out_o, .ch3_oe_o, .ch4_out_o,
    .ch4_oe_o, .ch3_capture_o, .ch4_capture_o, .update_o);
  tcc_pin_partner partner (.ext_i(ext), .ch3_out_i(ch3_out_o), .ch3_oe_i(ch3_oe_o), .ch4_out_i(ch4_out_o),
    .ch4_oe_i(ch4_oe_o), .ch3_pin_o(ch3_pin), .ch4_pin_o(ch4_pin), .trigger_o(trigger));
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  // Running tallies of capture and update pulses; scenarios compare differences
  always @(posedge clk_i) begin
    if (ch3_capture_o === 1'b1 || ch4_capture_o === 1'b1) caps <= caps + 1;
    if (update_o === 1'b1) ups <= ups + 1;
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Classic cycle; the request stands until ack is sampled high
  task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    sel_i <= 4'hF;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 16);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (ack_o !== 1'b1) begin
      fail_count++;
      conclude();
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rdchk(input string what, input logic [15:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h00000000);
    check(what, exp, rd);
  endtask
  // Output is registered, so allow a few cycles to settle
  task automatic expect_out(input string what, input logic ch4, input logic exp);
    logic v;
    for (int k = 0; k < 12; k++) begin
      @(negedge clk_i);
      v = ch4 ? ch4_out_o : ch3_out_o;
      if (v === exp) break;
    end
    check(what, exp, v);
  endtask
  task automatic pulses(input logic [2:0] s, input int w);
    repeat (12) begin
      @(posedge clk_i) ext <= s;
      repeat (w) @(posedge clk_i);
      ext <= 3'h0;
      repeat (w) @(posedge clk_i);
    end
  endtask
  // Direction changes only with the channel off; polarity settles before enabling
  task automatic cap_case(input logic [15:0] m, input logic [31:0] e, input logic [2:0] s, input int w, input int n);
    int base;
    wr(16'hE020, e & 32'h00002200);
    wr(16'hE01C, {16'h0000, m});
    repeat (8) @(posedge clk_i);
    wr(16'hE020, e);
    base = caps;
    pulses(s, w);
    repeat (20) @(posedge clk_i);
    check("capture count", n, caps - base);
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 4; i++) rdchk("reset value", 16'hE01C + 16'(4 * i), 32'h00000000);
    wr(16'hE01C, 32'hFFFFFFFF);
    rdchk("mode config", 16'hE01C, 32'h0000FFFF);
    wr(16'hE01C, 32'h00000000);
    wr(16'hE020, 32'hFFFFFFFF);
    rdchk("enable bits", 16'hE020, 32'h00003333);
    wr(16'hE100, 32'hFFFFFFFF);
    rdchk("unmapped", 16'hE100, 32'h00000000);
    // Forced levels through both polarities on both channels
    for (i = 0; i < 8; i++) begin
      wr(16'hE01C, 32'((i[1] ? 16'h50 : 16'h40) << (8 * i[2])));
      wr(16'hE020, 32'((i[0] ? 3 : 1) << (8 + 4 * i[2])));
      expect_out("forced level", i[2], i[1] ^ i[0]);
      check("drive enable", 1, i[2] ? ch4_oe_o : ch3_oe_o);
    end
    wr(16'hE020, 32'h00000100);
    wr(16'hE03C, 32'h00000040);
    foreach (tbl[k]) begin
      wr(16'hE01C, {24'h0, tbl[k][31:24]});
      wr(16'hE000, {24'h0, tbl[k][23:16]});
      wr(16'hE024, {24'h0, tbl[k][15:8]});
      expect_out("compare level", 1'b0, tbl[k][0]);
    end
    // Buffered compare waits for the update event
    wr(16'hE01C, 32'h00000068);
    wr(16'hE03C, 32'h00000080);
    rdchk("compare buffer", 16'hE03C, 32'h00000080);
    wr(16'hE024, 32'h00000060);
    expect_out("buffered compare", 1'b0, 1'b0);
    mark = ups;
    wr(16'hE000, 32'h00000100);
    wr(16'hE024, 32'h00000060);
    expect_out("loaded compare", 1'b0, 1'b1);
    check("update pulse", 1, ups - mark);
    // Trigger edge on channel 4, normal then fast
    wr(16'hE020, 32'h00000000);
    wr(16'hE01C, 32'h00000000);
    wr(16'hE040, 32'h00000040);
    wr(16'hE01C, 32'h00006800);
    wr(16'hE020, 32'h00001000);
    wr(16'hE024, 32'h00000010);
    expect_out("ch4 level", 1'b1, 1'b1);
    pulses(3'h4, 4);
    @(negedge clk_i);
    check("normal trigger", 1, ch4_out_o);
    wr(16'hE01C, 32'h00006C00);
    @(posedge clk_i) ext <= 3'h4;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    check("fast trigger", 0, ch4_out_o);
    @(posedge clk_i) ext <= 3'h0;
    // Counter clock divided by eight after an update
    wr(16'hE028, 32'h00000003);
    wr(16'hE000, 32'h00000100);
    wr(16'hE000, 32'h00000001);
    repeat (80) @(posedge clk_i);
    wr(16'hE000, 32'h00000000);
    wb(1'b0, 16'hE024, 32'h00000000);
    check("divided count", 1, rd >= 9 && rd <= 12);
    wr(16'hE020, 32'h00000000);
    cap_case(16'h0001, 32'h100, 3'h1, 3, 12);
    cap_case(16'h0005, 32'h100, 3'h1, 3, 6);
    cap_case(16'h0009, 32'h100, 3'h1, 3, 3);
    cap_case(16'h000D, 32'h100, 3'h1, 3, 2);
    cap_case(16'h0001, 32'h300, 3'h1, 3, 12);
    cap_case(16'h0001, 32'h000, 3'h1, 3, 0);
    cap_case(16'h0001, 32'h100, 3'h2, 3, 0);
    cap_case(16'h0002, 32'h100, 3'h2, 3, 12);
    cap_case(16'h0003, 32'h100, 3'h4, 3, 12);
    cap_case(16'h0000, 32'h100, 3'h1, 3, 0);
    cap_case(16'h0100, 32'h1000, 3'h2, 3, 12);
    cap_case(16'h0200, 32'h1000, 3'h1, 3, 12);
    cap_case(16'h0031, 32'h100, 3'h1, 3, 0);
    cap_case(16'h0031, 32'h100, 3'h1, 12, 12);
    cap_case(16'h00F1, 32'h100, 3'h1, 100, 0);
    cap_case(16'h00F1, 32'h100, 3'h1, 300, 12);
    conclude();
  end
  // Guard against a hung scenario
  initial begin
    repeat (80000) @(posedge clk_i);
    fail_count++;
    conclude();
  end
endmodule

// ---- sim/tcc_checker_properties.sv ----
// Port properties of the timer channel block
module tcc_checker (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic cyc_i, // Cycle
  input wire logic stb_i, // Strobe
  input wire logic ack_o, // Ack
  input wire logic [31:0] dat_o, // Read data
  input wire logic ch3_out_o, // Ch3 level
  input wire logic ch3_oe_o, // Ch3 drive
  input wire logic ch4_out_o, // Ch4 level
  input wire logic ch4_oe_o, // Ch4 drive
  input wire logic ch3_capture_o, // Ch3 capture
  input wire logic ch4_capture_o, // Ch4 capture
  input wire logic update_o // Update
);
  // One domain, so one clock and reset serve every property
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  bus_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("late ack");
  ack_single_a: assert property (ack_o |=> !ack_o)
    else $error("ack too long");
  ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  idle_data_a: assert property (!ack_o |-> dat_o == 32'h00000000)
    else $error("read data outside ack");
  ch3_gate_a: assert property (!ch3_oe_o |-> !ch3_out_o)
    else $error("ch3 level while off");
  ch4_gate_a: assert property (!ch4_oe_o |-> !ch4_out_o)
    else $error("ch4 level while off");
  out_no_capture_a: assert property (ch3_oe_o && $past(ch3_oe_o) && $past(ch3_oe_o, 2) |-> !ch3_capture_o)
    else $error("capture on output channel");
  capture_pulse_a: assert property (ch3_capture_o |=> !ch3_capture_o)
    else $error("capture pulse too long");
  update_pulse_a: assert property (update_o |=> !update_o)
    else $error("update pulse too long");
  reset_quiet_a: assert property ($fell(rst_i) |-> !ack_o && !ch3_oe_o && !ch4_oe_o && !update_o)
    else $error("outputs busy after reset");
  cover property (cyc_i && stb_i && ack_o);
  cover property (ch3_capture_o);
  cover property (ch4_capture_o);
  cover property (ch4_oe_o && ch4_out_o);
  cover property (update_o);
endmodule

bind timer_channel_capture_compare_cfg tcc_checker props (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .dat_o, .ch3_out_o,
  .ch3_oe_o, .ch4_out_o, .ch4_oe_o, .ch3_capture_o, .ch4_capture_o, .update_o);

// ---- sim/tcc_pin_partner.sv ----
// Outside parties on the channel pins and trigger lines
module tcc_pin_partner (
  input wire logic [2:0] ext_i, // Outside levels: pin 3, pin 4, trigger 0
  input wire logic ch3_out_i, // Block level, pin 3
  input wire logic ch3_oe_i, // Block drives pin 3
  input wire logic ch4_out_i, // Block level, pin 4
  input wire logic ch4_oe_i, // Block drives pin 4
  output logic ch3_pin_o, // Resolved pin 3
  output logic ch4_pin_o, // Resolved pin 4
  output logic [3:0] trigger_o // Trigger lines
);
  // Block wins while driving; the outside source only holds a released pin
  assign ch3_pin_o = ch3_oe_i ? ch3_out_i : ext_i[0];
  assign ch4_pin_o = ch4_oe_i ? ch4_out_i : ext_i[1];
  // Unused trigger sources idle low
  assign trigger_o = {3'h0, ext_i[2]};
endmodule
